// ---- core/dfu_bcd2bin.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dfu_consts.svh"

module dfu_bcd2bin (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // request
  input  wire logic        start,
  input  wire logic [71:0] digits,
  // result
  output logic             done,
  output logic [59:0]      bin
);

  logic [71:0] dig;
  logic [4:0]  cnt;
  logic        run;
  logic [71:0] next_dig;
  logic [4:0]  next_cnt;
  logic        next_run;
  logic        next_done;
  logic [59:0] next_bin;

  // msd first, acc = acc*10 + digit; shifts avoid a multiplier
  always_comb begin
    next_dig  = dig;
    next_cnt  = cnt;
    next_run  = run;
    next_bin  = bin;
    next_done = 1'b0;
    if (start) begin
      next_dig = digits;
      next_cnt = `DFU_NDIG;
      next_run = 1'b1;
      next_bin = '0;
    end else if (run) begin
      next_bin = (bin << 3) + (bin << 1) + {56'h0, dig[71:68]};
      next_dig = {dig[67:0], 4'h0};
      next_cnt = cnt - 5'h01;
      if (cnt == 5'h01) begin
        next_run  = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dig  <= '0;
      cnt  <= '0;
      run  <= 1'b0;
      done <= 1'b0;
      bin  <= '0;
    end else begin
      dig  <= next_dig;
      cnt  <= next_cnt;
      run  <= next_run;
      done <= next_done;
      bin  <= next_bin;
    end
  end

endmodule
`default_nettype wire

// ---- core/dfu_bin2bcd.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dfu_consts.svh"

module dfu_bin2bcd (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // request
  input  wire logic        start,
  input  wire logic [59:0] bin,
  // result
  output logic             done,
  output logic [71:0]      bcd
);

  logic [59:0] sh;
  logic [5:0]  cnt;
  logic        run;
  logic [59:0] next_sh;
  logic [5:0]  next_cnt;
  logic        next_run;
  logic        next_done;
  logic [71:0] next_bcd;
  logic [71:0] adj;

  // add three to every digit above four before each shift
  function automatic logic [71:0] dabble(input logic [71:0] v);
    logic [71:0] r;
    r = v;
    for (int i = 0; i < 18; i++) begin
      if (v[i*4 +: 4] > 4'h4) begin
        r[i*4 +: 4] = v[i*4 +: 4] + 4'h3;
      end
    end
    return r;
  endfunction

  // one bit per cycle, msb first
  always_comb begin
    adj       = dabble(bcd);
    next_sh   = sh;
    next_cnt  = cnt;
    next_run  = run;
    next_bcd  = bcd;
    next_done = 1'b0;
    if (start) begin
      next_sh  = bin;
      next_cnt = `DFU_NBITS;
      next_run = 1'b1;
      next_bcd = '0;
    end else if (run) begin
      next_bcd = {adj[70:0], sh[59]};
      next_sh  = {sh[58:0], 1'b0};
      next_cnt = cnt - 6'h01;
      if (cnt == 6'h01) begin
        next_run  = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh   <= '0;
      cnt  <= '0;
      run  <= 1'b0;
      done <= 1'b0;
      bcd  <= '0;
    end else begin
      sh   <= next_sh;
      cnt  <= next_cnt;
      run  <= next_run;
      done <= next_done;
      bcd  <= next_bcd;
    end
  end

endmodule
`default_nettype wire

// ---- core/dfu_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dfu_consts.svh"

module dfu_top (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // request from the execution core
  input  wire logic                req_valid,
  input  wire dfu_pkg::dfu_req_t   req,
  output logic                     busy,
  // response
  output logic                     resp_valid,
  output logic [79:0]              resp_data,
  output dfu_pkg::dfu_flags_t      resp_flags
);

  dfu_pkg::dfu_state_t state;
  dfu_pkg::dfu_state_t next_state;
  dfu_pkg::dfu_op_t    cur_op;
  dfu_pkg::dfu_op_t    next_cur_op;
  dfu_pkg::dfu_flags_t hold;
  dfu_pkg::dfu_flags_t next_hold;
  dfu_pkg::dfu_flags_t next_resp_flags;
  logic                next_busy;
  logic                next_resp_valid;
  logic [79:0]         next_resp_data;
  logic                take;
  logic                dec_start;
  logic                enc_start;
  logic                dec_done;
  logic                enc_done;
  logic [59:0]         dec_bin;
  logic [71:0]         enc_bcd;
  logic [60:0]         st_mag;
  logic [63:0]         norm_v;
  logic [6:0]          lz;
  logic [7:0]          s_exp;
  logic [22:0]         s_frac;
  logic [3:0]          dig;

  // leading zero count of a 64-bit significand
  function automatic logic [6:0] lzc64(input logic [63:0] v);
    logic [6:0] n;
    n = 7'h40;
    for (int i = 0; i < 64; i++) begin
      if (v[i]) begin
        n = 7'(63 - i);
      end
    end
    return n;
  endfunction

  // any nibble above nine in an eighteen digit field
  function automatic logic bcd_bad(input logic [71:0] v);
    logic b;
    b = 1'b0;
    for (int i = 0; i < 18; i++) begin
      if (v[i*4 +: 4] > `DFU_DIGIT_MAX) begin
        b = 1'b1;
      end
    end
    return b;
  endfunction

  // extended value to integer magnitude, {invalid, magnitude}
  function automatic logic [60:0] store_mag(input logic [79:0] x);
    logic [16:0] e;
    logic [63:0] s;
    logic [60:0] r;
    e = {2'b00, x[78:64]} - {2'b00, `DFU_EXT_BIAS};
    s = '0;
    r = '0;
    if (x[78:64] == `DFU_EXT_EXP_TOP) begin
      r = {1'b1, 60'h0};
    end else if (x[78:64] < `DFU_EXT_BIAS) begin
      r = '0; // fraction only, truncated to zero
    end else if (e > `DFU_MAX_SHIFT) begin
      r = {1'b1, 60'h0};
    end else begin
      s = x[63:0] >> (6'h3f - e[5:0]);
      r = {s[59:0] > `DFU_MAG_MAX, s[59:0]};
    end
    return r;
  endfunction

  assign take = req_valid && (state == dfu_pkg::DFU_IDLE);

  dfu_bcd2bin u_dec (
    .clk    (clk),
    .rst_b  (rst_b),
    .start  (dec_start),
    .digits (req.data[71:0]),
    .done   (dec_done),
    .bin    (dec_bin)
  );

  dfu_bin2bcd u_enc (
    .clk   (clk),
    .rst_b (rst_b),
    .start (enc_start),
    .bin   (st_mag[59:0]),
    .done  (enc_done),
    .bcd   (enc_bcd)
  );

  // sequencing and result formation; the decimal paths run iteratively
  // to keep area small at the cost of tens of cycles per operation
  always_comb begin
    next_state      = state;
    next_cur_op     = cur_op;
    next_hold       = hold;
    next_resp_valid = 1'b0;
    next_resp_data  = resp_data;
    next_resp_flags = resp_flags;
    dec_start       = 1'b0;
    enc_start       = 1'b0;
    st_mag          = store_mag(req.data);
    norm_v          = '0;
    lz              = '0;
    s_exp           = req.data[30:23];
    s_frac          = req.data[22:0];
    dig             = '0;
    case (state)
      dfu_pkg::DFU_IDLE: begin
        if (take) begin
          next_cur_op = req.op;
          next_hold   = '0;
          case (req.op)
            dfu_pkg::DFU_OP_LOAD_DEC: begin
              dec_start            = 1'b1;
              next_hold.sign       = req.data[79];
              next_hold.digit_err  = bcd_bad(req.data[71:0]);
              next_state           = dfu_pkg::DFU_LOAD_RUN;
            end
            dfu_pkg::DFU_OP_STORE_DEC: begin
              next_hold.sign = req.data[79];
              if (st_mag[60]) begin
                next_resp_valid         = 1'b1;
                next_resp_flags         = '0;
                next_resp_flags.invalid = 1'b1;
                next_resp_flags.sign    = req.data[79];
                next_resp_data          = req.inv_masked ?
                                          `DFU_INDEF : '0;
              end else begin
                enc_start  = 1'b1;
                next_state = dfu_pkg::DFU_STORE_RUN;
              end
            end
            dfu_pkg::DFU_OP_UNPK_PK: begin
              next_resp_valid = 1'b1;
              next_resp_flags = '0;
              next_resp_data  = '0;
              for (int i = 0; i < 8; i++) begin
                dig = req.data[i*8 +: 4];
                next_resp_data[i*4 +: 4] = dig;
                if (dig > `DFU_DIGIT_MAX) begin
                  next_resp_flags.digit_err = 1'b1;
                end
                if (req.muldiv && (req.data[i*8+4 +: 4] != 4'h0)) begin
                  next_resp_flags.digit_err = 1'b1;
                end
              end
            end
            dfu_pkg::DFU_OP_PK_UNPK: begin
              next_resp_valid = 1'b1;
              next_resp_flags = '0;
              next_resp_data  = '0;
              for (int i = 0; i < 8; i++) begin
                dig = req.data[i*4 +: 4];
                next_resp_data[i*8 +: 8] = {4'h0, dig};
                if (dig > `DFU_DIGIT_MAX) begin
                  next_resp_flags.digit_err = 1'b1;
                end
              end
            end
            dfu_pkg::DFU_OP_SGL_EXT: begin
              next_resp_valid      = 1'b1;
              next_resp_flags      = '0;
              next_resp_flags.sign = req.data[31];
              if (s_exp == 8'h00 && s_frac == 23'h0) begin
                next_resp_data = {req.data[31], 79'h0};
              end else if (s_exp == 8'h00) begin
                // denormal: integer bit zero, normalize it
                norm_v = {1'b0, s_frac, 40'h0};
                lz     = lzc64(norm_v);
                next_resp_data = {req.data[31],
                  `DFU_EXT_BIAS - `DFU_SGL_DEN_EXP - {8'h00, lz},
                  norm_v << lz};
              end else if (s_exp == `DFU_SGL_EXP_TOP) begin
                next_resp_data = {req.data[31], `DFU_EXT_EXP_TOP,
                                  1'b1, s_frac, 40'h0};
              end else begin
                next_resp_data = {req.data[31],
                  {7'h00, s_exp} - `DFU_SGL_BIAS + `DFU_EXT_BIAS,
                  1'b1, s_frac, 40'h0};
              end
            end
            dfu_pkg::DFU_OP_VEC_SIGNS: begin
              // top bit of each lane, lane 0 in bit 0
              next_resp_valid = 1'b1;
              next_resp_flags = '0;
              next_resp_data  = '0;
              for (int i = 0; i < 16; i++) begin
                if (req.lane == `DFU_LANE_BYTE) begin
                  next_resp_data[i] = req.vec[i*8+7];
                end else if (req.lane == `DFU_LANE_WORD && i < 8) begin
                  next_resp_data[i] = req.vec[i*16+15];
                end else if (req.lane == `DFU_LANE_DWORD && i < 4) begin
                  next_resp_data[i] = req.vec[i*32+31];
                end else if (i < 2) begin
                  next_resp_data[i] = req.vec[i*64+63];
                end
              end
            end
            default: begin
              next_resp_valid = 1'b1;
              next_resp_flags = '0;
              next_resp_flags.invalid = 1'b1;
              next_resp_data  = '0;
            end
          endcase
        end
      end
      dfu_pkg::DFU_LOAD_RUN: begin
        if (dec_done) begin
          // exact: 60 bits of magnitude fit the 64-bit significand
          norm_v          = {4'h0, dec_bin};
          lz              = lzc64(norm_v);
          next_resp_valid = 1'b1;
          next_resp_flags = hold;
          next_state      = dfu_pkg::DFU_IDLE;
          if (dec_bin == 60'h0) begin
            next_resp_data = {hold.sign, 79'h0};
          end else begin
            next_resp_data = {hold.sign,
              `DFU_EXT_BIAS + {8'h00, `DFU_INT_BIT} - {8'h00, lz},
              norm_v << lz};
          end
        end
      end
      dfu_pkg::DFU_STORE_RUN: begin
        if (enc_done) begin
          next_resp_valid = 1'b1;
          next_resp_flags = hold;
          next_resp_data  = {hold.sign, 7'h00, enc_bcd};
          next_state      = dfu_pkg::DFU_IDLE;
        end
      end
      default: begin
        next_state = dfu_pkg::DFU_IDLE;
      end
    endcase
    next_busy = (next_state != dfu_pkg::DFU_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= dfu_pkg::DFU_IDLE;
      cur_op     <= dfu_pkg::DFU_OP_LOAD_DEC;
      hold       <= '0;
      busy       <= 1'b0;
      resp_valid <= 1'b0;
      resp_data  <= '0;
      resp_flags <= '0;
    end else begin
      state      <= next_state;
      cur_op     <= next_cur_op;
      hold       <= next_hold;
      busy       <= next_busy;
      resp_valid <= next_resp_valid;
      resp_data  <= next_resp_data;
      resp_flags <= next_resp_flags;
    end
  end

  // checks
  a_indef_store: assert property (
    @(posedge clk) disable iff (!rst_b)
    take && req.op == dfu_pkg::DFU_OP_STORE_DEC && req.inv_masked &&
    req.data[78:64] == `DFU_EXT_EXP_TOP |=> resp_valid &&
    resp_flags.invalid && resp_data == `DFU_INDEF)
    else $error("masked invalid store did not give indefinite");

  a_sign_byte_zero: assert property (
    @(posedge clk) disable iff (!rst_b)
    resp_valid && cur_op == dfu_pkg::DFU_OP_STORE_DEC &&
    !resp_flags.invalid |-> resp_data[78:72] == 7'h00 &&
    resp_data[79] == resp_flags.sign)
    else $error("store sign byte low bits not zero");

  a_load_latency: assert property (
    @(posedge clk) disable iff (!rst_b)
    take && req.op == dfu_pkg::DFU_OP_LOAD_DEC |->
    !resp_valid [*8] ##13 resp_valid)
    else $error("decimal load result not at cycle twenty");

  a_store_bound: assert property (
    @(posedge clk) disable iff (!rst_b)
    take && req.op == dfu_pkg::DFU_OP_STORE_DEC |->
    ##[1:64] resp_valid)
    else $error("decimal store never answered");

  a_norm_int_bit: assert property (
    @(posedge clk) disable iff (!rst_b)
    resp_valid && !resp_flags.invalid &&
    (cur_op == dfu_pkg::DFU_OP_LOAD_DEC ||
     cur_op == dfu_pkg::DFU_OP_SGL_EXT) &&
    resp_data[78:64] != 15'h0 |-> resp_data[63])
    else $error("nonzero result not normalized");

  a_load_exp_range: assert property (
    @(posedge clk) disable iff (!rst_b)
    resp_valid && cur_op == dfu_pkg::DFU_OP_LOAD_DEC && resp_data[63]
    |-> resp_data[78:64] >= 15'h3fff && resp_data[78:64] <= 15'h403a)
    else $error("loaded exponent outside biased range");

  a_sgl_bias: assert property (
    @(posedge clk) disable iff (!rst_b)
    take && req.op == dfu_pkg::DFU_OP_SGL_EXT &&
    req.data[30:23] != 8'h00 && req.data[30:23] != 8'hff |=>
    resp_data[78:64] == {7'h00, $past(req.data[30:23])} + 15'h3f80)
    else $error("single exponent rebias wrong");

  a_unpk_clear: assert property (
    @(posedge clk) disable iff (!rst_b)
    take && req.op == dfu_pkg::DFU_OP_PK_UNPK |=> resp_valid &&
    resp_data[7:4] == 4'h0 && resp_data[63:60] == 4'h0 &&
    resp_data[3:0] == $past(req.data[3:0]))
    else $error("unpacked high nibble not cleared");

  a_resp_pulse: assert property (
    @(posedge clk) disable iff (!rst_b)
    resp_valid && !take |=> !resp_valid)
    else $error("response held longer than one cycle");

endmodule
`default_nettype wire

// ---- pkg/dfu_consts.svh ----
`ifndef DFU_CONSTS_SVH
`define DFU_CONSTS_SVH

// double-extended layout
`define DFU_EXT_BIAS     15'h3fff
`define DFU_EXT_EXP_TOP  15'h7fff
`define DFU_INT_BIT      7'h3f

// single-precision layout
`define DFU_SGL_BIAS     15'h007f
`define DFU_SGL_DEN_EXP  15'h007e
`define DFU_SGL_EXP_TOP  8'hff

// packed decimal memory format
`define DFU_NDIG         5'h12
`define DFU_NBITS        6'h3c
`define DFU_MAX_SHIFT    17'h0003b
`define DFU_DIGIT_MAX    4'h9
`define DFU_MAG_MAX      60'hde0_b6b3_a763_ffff
`define DFU_INDEF        80'hffff_c000_0000_0000_0000

// vector lane sizes
`define DFU_LANE_BYTE    2'h0
`define DFU_LANE_WORD    2'h1
`define DFU_LANE_DWORD   2'h2

`endif

// ---- pkg/dfu_pkg.sv ----
`default_nettype none
package dfu_pkg;

  // operations issued by the execution core
  typedef enum logic [2:0] {
    DFU_OP_LOAD_DEC  = 3'b000,
    DFU_OP_STORE_DEC = 3'b001,
    DFU_OP_UNPK_PK   = 3'b010,
    DFU_OP_PK_UNPK   = 3'b011,
    DFU_OP_SGL_EXT   = 3'b100,
    DFU_OP_VEC_SIGNS = 3'b101
  } dfu_op_t;

  typedef enum logic [1:0] {
    DFU_IDLE      = 2'b00,
    DFU_LOAD_RUN  = 2'b01,
    DFU_STORE_RUN = 2'b10
  } dfu_state_t;

  typedef struct packed {
    dfu_op_t      op;
    logic [79:0]  data;
    logic [127:0] vec;
    logic [1:0]   lane;
    logic         muldiv;
    logic         inv_masked;
  } dfu_req_t;

  typedef struct packed {
    logic invalid;
    logic digit_err;
    logic sign;
  } dfu_flags_t;

endpackage
`default_nettype wire

// ---- sim/decimal_and_float_format_unit_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dfu_consts.svh"

module decimal_and_float_format_unit_tb;
  logic                clk;
  logic                rst_b;
  logic                req_valid;
  logic                busy;
  logic                resp_valid;
  logic [79:0]         resp_data;
  dfu_pkg::dfu_req_t   req;
  dfu_pkg::dfu_flags_t resp_flags;
  dfu_pkg::dfu_req_t   r;
  logic [79:0]         x;
  longint unsigned     mag;
  int                  fails;
  int                  cmp_count;
  int                  cycles;
  int                  busy_cnt;
  logic [31:0]         sgl_tbl [7];

  dfu_top dut (
    .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .busy(busy), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_flags(resp_flags)
  );

  dfu_core_model core (
    .clk(clk), .rst_b(rst_b), .req(req), .req_valid(req_valid),
    .resp_valid(resp_valid)
  );

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // normalised double-extended value of m * 2^sc
  function automatic logic [79:0] to_ext(input logic s,
      input logic [63:0] m, input int sc);
    int p = 63;
    if (m == 64'h0) return {s, 79'h0};
    while (m[p] == 1'b0) p--;
    return {s, 15'(16383 + sc + p), m << (63 - p)};
  endfunction

  function automatic longint unsigned dec_val(input logic [71:0] d);
    dec_val = 0;
    for (int i = 17; i >= 0; i--) dec_val = dec_val * 10 + d[4*i +: 4];
  endfunction

  function automatic logic [71:0] to_bcd(input longint unsigned v);
    to_bcd = '0;
    for (int i = 0; i < 18; i++) begin
      to_bcd[4*i +: 4] = 4'(v % 10);
      v = v / 10;
    end
  endfunction

  function automatic dfu_pkg::dfu_req_t mk(input logic [2:0] op,
      input logic [79:0] d);
    mk = '0;
    mk.op = dfu_pkg::dfu_op_t'(op);
    mk.data = d;
    mk.vec = {$urandom, $urandom, $urandom, $urandom};
    mk.lane = 2'($urandom);
  endfunction

  // reference result; f is {invalid, digit_err, sign}
  task automatic model(input dfu_pkg::dfu_req_t q, output logic [79:0] d,
      output logic [2:0] f, output int lat);
    longint unsigned mg;
    int e;
    int n;
    d = '0;
    f = '0;
    lat = 1;
    case (q.op)
      dfu_pkg::DFU_OP_LOAD_DEC: begin
        lat = 20;
        f[0] = q.data[79];
        d = to_ext(q.data[79], dec_val(q.data[71:0]), 0);
      end
      dfu_pkg::DFU_OP_STORE_DEC: begin
        e = int'(q.data[78:64]) - 16383;
        mg = (e < 0) ? 0 : (e >= 60) ? '1 : q.data[63:0] >> (63 - e);
        if (q.data[78:64] == 15'h7fff || mg >= 64'd1000000000000000000)
        begin
          f[2] = 1'b1;
          d = q.inv_masked ? `DFU_INDEF : '0;
        end else begin
          lat = 62;
          d = {q.data[79], 7'h0, to_bcd(mg)};
        end
      end
      dfu_pkg::DFU_OP_UNPK_PK: for (int i = 0; i < 8; i++) begin
        d[4*i +: 4] = q.data[8*i +: 4];
        if (q.data[8*i +: 4] > 4'h9) f[1] = 1'b1;
        if (q.muldiv && q.data[8*i+4 +: 4] != 4'h0) f[1] = 1'b1;
      end
      dfu_pkg::DFU_OP_PK_UNPK: for (int i = 0; i < 8; i++) begin
        d[8*i +: 8] = {4'h0, q.data[4*i +: 4]};
        if (q.data[4*i +: 4] > 4'h9) f[1] = 1'b1;
      end
      dfu_pkg::DFU_OP_SGL_EXT: begin
        e = int'(q.data[30:23]);
        if (e == 255) d = {q.data[31], 15'h7fff, 1'b1, q.data[22:0], 40'h0};
        else if (e == 0) d = to_ext(q.data[31], 64'(q.data[22:0]), -149);
        else d = to_ext(q.data[31], {41'h1, q.data[22:0]}, e - 150);
      end
      dfu_pkg::DFU_OP_VEC_SIGNS: begin
        n = 16 >> q.lane;
        for (int i = 0; i < n; i++) d[i] = q.vec[(128 / n) * (i + 1) - 1];
      end
      default: f[2] = 1'b1;
    endcase
  endtask

  task automatic compare(input logic [79:0] got, input logic [79:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // issue through the core model and compare data, flags and latency
  task automatic run(input dfu_pkg::dfu_req_t q);
    logic [79:0] ed;
    logic [2:0]  ef;
    logic [2:0]  m;
    int          el;
    int          lat;
    model(q, ed, ef, el);
    busy_cnt = 0;
    core.issue(q, lat);
    // sign flag is only compared for decimal loads
    m = (q.op == dfu_pkg::DFU_OP_LOAD_DEC) ? 3'b111 : 3'b110;
    compare(resp_data, ed);
    compare({77'h0, resp_flags & m}, {77'h0, ef & m});
    compare(80'(lat), 80'(el));
    // busy stands from the take until the answer edge
    compare(80'(busy_cnt), 80'(el - 1));
  endtask

  // busy cycles seen between take and answer
  always @(negedge clk) begin
    if (busy === 1'b1) busy_cnt++;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // hang guard, far beyond the fewer than one thousand cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    fails = 0;
    cmp_count = 0;
    cycles = 0;
    rst_b = 1'b0;
    sgl_tbl = '{32'h4332_2000, 32'h8000_0000, 32'h0000_0001, 32'h807f_ffff,
                32'h7f80_0000, 32'hffc0_0001, 32'h0080_0000};
    void'($urandom(61));
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    // digits only 0..9, so the indefinite pattern is never loaded
    for (int k = 0; k < 10; k++) begin
      x = {1'($urandom), 7'($urandom), 72'h0};
      for (int i = 0; i < 18; i++) x[4*i +: 4] = 4'($urandom_range(9));
      if (k == 0) x[71:0] = {18{4'h9}};
      if (k == 1) x = {1'b1, 79'h0};
      if (k == 2) x[71:0] = 72'h1;
      run(mk(dfu_pkg::DFU_OP_LOAD_DEC, x));
    end
    $display("test decimal load done");
    for (int k = 0; k < 12; k++) begin
      mag = {$urandom, $urandom} % 64'd1000000000000000000;
      if (k == 0) mag = 64'd999999999999999999;
      if (k == 1) mag = 64'd1000000000000000000;
      x = to_ext(1'($urandom), mag, 0);
      // random fraction below the integer part must be truncated
      x[63:0] = x[63:0] | ({$urandom, $urandom} >> (int'(x[78:64]) - 16382));
      if (k == 2) x[78:64] = 15'h7fff;
      if (k == 3) x = {1'b1, 15'h3ffe, 64'hc000_0000_0000_0000};
      if (k == 4) x[78:64] = 15'h7fff;
      r = mk(dfu_pkg::DFU_OP_STORE_DEC, x);
      // masked and unmasked forms of the top-exponent cause, only the masked form of the too-large magnitude
      r.inv_masked = k[0] || k == 2;
      run(r);
    end
    $display("test decimal store done");
    for (int k = 0; k < 16; k++) begin
      x = '0;
      for (int i = 0; i < 8; i++) begin
        x[8*i +: 8] = {(k == 5) ? 4'h0 : 4'($urandom), 4'($urandom_range(9))};
      end
      if (k >= 8) x[79:32] = '0;
      if (k == 6 || k == 12) x[11:8] = 4'hb;
      r = mk(k < 8 ? dfu_pkg::DFU_OP_UNPK_PK : dfu_pkg::DFU_OP_PK_UNPK, x);
      // nonzero high nibbles with muldiv set must be flagged
      r.muldiv = k[0];
      run(r);
    end
    $display("test bcd pack done");
    for (int k = 0; k < 14; k++) begin
      x = {48'h0, (k < 7) ? sgl_tbl[k] : 32'($urandom)};
      run(mk(dfu_pkg::DFU_OP_SGL_EXT, x));
    end
    $display("test single convert done");
    for (int k = 0; k < 8; k++) begin
      r = mk(dfu_pkg::DFU_OP_VEC_SIGNS, {$urandom, $urandom, 16'($urandom)});
      r.lane = 2'(k);
      run(r);
    end
    run(mk(3'b110, '1));
    run(mk(3'b111, '1));
    $display("test lanes and unknown ops done");
    give_verdict();
  end
endmodule

`default_nettype wire

// ---- sim/dfu_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module dfu_core_model (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // request side
  output dfu_pkg::dfu_req_t req,
  output logic              req_valid,
  // response side
  input  wire logic         resp_valid
);
  // quiet until the first request
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // one request at a time: held through the take edge, then released
  task automatic issue(input dfu_pkg::dfu_req_t r, output int lat);
    @(negedge clk);
    req_valid = 1'b1;
    req = r;
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    // released operand is scrambled so a stale copy cannot pass
    req = ~r;
    lat = 1;
    while (resp_valid !== 1'b1 && lat < 100) begin
      @(negedge clk);
      lat++;
    end
  endtask
endmodule

`default_nettype wire
